// ---- src/osp_sync_params.sv ----
// APB register bank and timing logic for the output synchronization parameters.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "osp_consts.svh"

module osp_sync_params
	import osp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sm_event,
	input  wire logic        sync0,
	input  wire logic        sync1,
	input  wire logic        op_state,
	input  wire logic        out_data_ready,
	input  wire logic        out_done,
	output logic             out_update,
	output logic             sync_error_pdo,
	output logic             irq
);

	// ------------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------------

	// Register index of a byte address; low two bits must be zero.
	function automatic logic [7:0] reg_index(input logic [7:0] addr);
		reg_index = {2'b00, addr[7:2]};
	endfunction

	// True for every aligned address whose index holds a register.
	function automatic logic reg_mapped(input logic [7:0] addr);
		logic [7:0] idx;
		idx = reg_index(addr);
		reg_mapped = (addr[1:0] == 2'b00) && (
			idx == `OSP_IDX_ENTRY_COUNT   || idx == `OSP_IDX_MODE_SELECT  ||
			idx == `OSP_IDX_CYCLE_PERIOD  || idx == `OSP_IDX_OUTPUT_SHIFT ||
			idx == `OSP_IDX_SUPPORTED     || idx == `OSP_IDX_MIN_CYCLE    ||
			idx == `OSP_IDX_EVENT_GAP     || idx == `OSP_IDX_MEASURE_CTRL ||
			idx == `OSP_IDX_OUTPUT_DELAY  || idx == `OSP_IDX_MISSED_COUNT ||
			idx == `OSP_IDX_OVERRUN_COUNT || idx == `OSP_IDX_SHORT_GAP    ||
			idx == `OSP_IDX_LATE_FLAG     || idx == `OSP_IDX_IRQ_STATUS   ||
			idx == `OSP_IDX_IRQ_MASK);
	endfunction

	// Both distributed-clock modes.
	function automatic logic is_dc(input logic [15:0] mode);
		is_dc = (mode == `OSP_MODE_DC_SYNC0) || (mode == `OSP_MODE_DC_SYNC1);
	endfunction

	// Elapsed-time counters stick at the top instead of wrapping.
	function automatic osp_word_t sat_add(input osp_word_t t);
		sat_add = (t > (32'hFFFFFFFF - `OSP_NS_PER_CYCLE)) ? 32'hFFFFFFFF : t + `OSP_NS_PER_CYCLE;
	endfunction

	// ------------------------------------------------------------------------
	// State and counters
	// ------------------------------------------------------------------------
	osp_state_s  st_reg;
	osp_state_s  st_next;
	logic [2:0]  cnt_inc;
	logic [2:0]  cnt_clr;
	logic [15:0] cnt_val [3];
	logic        wr_access;
	logic        rd_setup;
	logic [7:0]  acc_idx;
	logic        mode_dc;
	logic        cycle_start;
	logic        fire;
	logic        ev_missed;
	logic        ev_overrun;
	logic        ev_short;
	logic        ev_late;
	logic [3:0]  ev_vec;

	// Three identical diagnostic counters: missed, overrun, short gap.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_cnt
			osp_sat_counter #(.WIDTH(16)) u_cnt (
				.pclk    (pclk),
				.presetn (presetn),
				.inc     (cnt_inc[gi]),
				.clr     (cnt_clr[gi]),
				.count   (cnt_val[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Bus phase and event detection
	// ------------------------------------------------------------------------

	// Writes act in the access phase; read data is captured in setup so that
	// it comes from a flop while pready stays tied high.
	assign wr_access = psel && penable && pwrite;
	assign rd_setup  = psel && !penable;
	assign acc_idx   = reg_index(paddr);
	assign mode_dc   = is_dc(st_reg.mode);

	// The cycle is paced by the local timer, the SM event or a sync event.
	always_comb begin
		case (st_reg.mode)
			`OSP_MODE_FREE_RUN: cycle_start = (st_reg.timer_ns >= st_reg.cycle_period);
			`OSP_MODE_SM_EVENT: cycle_start = sm_event;
			`OSP_MODE_DC_SYNC0: cycle_start = sync0;
			`OSP_MODE_DC_SYNC1: cycle_start = sync1;
			default:            cycle_start = 1'b0;
		endcase
	end

	// Output strobe: immediate in free run and SM mode, delayed in DC modes.
	always_comb begin
		case (st_reg.mode)
			`OSP_MODE_FREE_RUN: fire = cycle_start;
			`OSP_MODE_SM_EVENT: fire = sm_event;
			`OSP_MODE_DC_SYNC0: fire = st_reg.armed && (st_reg.arm_ns >= st_reg.output_shift);
			`OSP_MODE_DC_SYNC1: fire = st_reg.armed && (st_reg.arm_ns >= st_reg.output_delay);
			default:            fire = 1'b0;
		endcase
	end

	// A SYNC0 with no SM event since the previous one means the event was lost.
	assign ev_missed  = mode_dc && op_state && sync0 && !(st_reg.sm_seen || sm_event);
	// A new cycle that finds the previous one unfinished is an overrun.
	assign ev_overrun = op_state && cycle_start && st_reg.busy && !out_done;
	// The SYNC1 came sooner after SYNC0 than the programmed interval.
	assign ev_short   = mode_dc && sync1 && (st_reg.s0_ns < st_reg.event_gap);
	// Outputs strobed before the application delivered its data are late.
	assign ev_late    = mode_dc && fire && !(st_reg.data_seen || out_data_ready);
	assign ev_vec     = {ev_late, ev_short, ev_overrun, ev_missed};

	// Writing zero to a counter clears it; other values are ignored.
	always_comb begin
		cnt_inc    = {ev_short, ev_overrun, ev_missed};
		cnt_clr[0] = wr_access && acc_idx == `OSP_IDX_MISSED_COUNT  && pwdata[15:0] == 16'h0000;
		cnt_clr[1] = wr_access && acc_idx == `OSP_IDX_OVERRUN_COUNT && pwdata[15:0] == 16'h0000;
		cnt_clr[2] = wr_access && acc_idx == `OSP_IDX_SHORT_GAP     && pwdata[15:0] == 16'h0000;
	end

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------
	always_comb begin
		st_next            = st_reg;
		st_next.out_update = fire;

		// Elapsed-time trackers in nanoseconds, advanced by one clock period.
		// They restart at one period so that the next event reads the whole interval, not one clock less.
		st_next.cyc_ns   = cycle_start ? `OSP_NS_PER_CYCLE : sat_add(st_reg.cyc_ns);
		st_next.s0_ns    = sync0 ? `OSP_NS_PER_CYCLE : sat_add(st_reg.s0_ns);
		st_next.s1_ns    = sync1 ? `OSP_NS_PER_CYCLE : sat_add(st_reg.s1_ns);
		st_next.timer_ns = (st_reg.mode != `OSP_MODE_FREE_RUN || cycle_start) ?
			`OSP_NS_PER_CYCLE : sat_add(st_reg.timer_ns);

		// Arm the delayed strobe on the reference event of the DC mode.
		if ((st_reg.mode == `OSP_MODE_DC_SYNC0 && sync0) ||
			(st_reg.mode == `OSP_MODE_DC_SYNC1 && sync1)) begin
			st_next.armed  = 1'b1;
			st_next.arm_ns = `OSP_NS_PER_CYCLE;
		end else if (fire || !mode_dc) begin
			st_next.armed  = 1'b0;
			st_next.arm_ns = 32'h00000000;
		end else begin
			st_next.arm_ns = sat_add(st_reg.arm_ns);
		end

		// Cycle bookkeeping for the missed, overrun and late checks.
		st_next.sm_seen   = sm_event || (st_reg.sm_seen && !sync0);
		st_next.busy      = cycle_start || (st_reg.busy && !out_done);
		st_next.data_seen = out_data_ready || (st_reg.data_seen && !cycle_start && !fire);

		// Register writes in the access phase; read-only targets are refused.
		if (wr_access) begin
			case (acc_idx)
				`OSP_IDX_MODE_SELECT:  st_next.mode         = pwdata[15:0];
				`OSP_IDX_CYCLE_PERIOD: st_next.cycle_period = pwdata;
				`OSP_IDX_OUTPUT_SHIFT: st_next.output_shift = pwdata;
				`OSP_IDX_SUPPORTED:    st_next.supported    = pwdata[15:0];
				`OSP_IDX_MIN_CYCLE:    st_next.min_cycle    = pwdata;
				`OSP_IDX_EVENT_GAP:    st_next.event_gap    = pwdata;
				`OSP_IDX_OUTPUT_DELAY: st_next.output_delay = pwdata;
				`OSP_IDX_LATE_FLAG:    st_next.late_flag    = pwdata[0];
				`OSP_IDX_IRQ_MASK:     st_next.irq_mask     = pwdata[3:0];
				`OSP_IDX_IRQ_STATUS:   st_next.irq_status   = st_reg.irq_status & ~pwdata[3:0];
				`OSP_IDX_MEASURE_CTRL: begin
					st_next.measure_ctrl = pwdata[15:0];
					// Rising into measurement wipes the old maxima first.
					if (pwdata[`OSP_MEASURE_BIT] && !st_reg.measure_ctrl[`OSP_MEASURE_BIT]) begin
						st_next.min_cycle    = 32'h00000000;
						st_next.event_gap    = 32'h00000000;
						st_next.output_delay = 32'h00000000;
					end
				end
				default: begin
				end
			endcase
		end

		// Measurement keeps the largest observed values; a sample larger than
		// a concurrent write replaces the written value.
		if (st_reg.measure_ctrl[`OSP_MEASURE_BIT]) begin
			if (cycle_start && st_reg.cyc_ns > st_next.min_cycle) begin
				st_next.min_cycle = st_reg.cyc_ns;
			end
			if (sync1 && st_reg.s0_ns > st_next.event_gap) begin
				st_next.event_gap = st_reg.s0_ns;
			end
			if (out_done && st_reg.s1_ns > st_next.output_delay) begin
				st_next.output_delay = st_reg.s1_ns;
			end
		end

		// Late flag is renewed on every DC strobe; hardware set beats a write.
		if (mode_dc && fire) begin
			st_next.late_flag = ev_late || (st_next.late_flag && ev_late);
		end
		if (ev_late) begin
			st_next.late_flag = 1'b1;
		end

		// Sticky status: a new event wins over a clear in the same cycle.
		st_next.irq_status = st_next.irq_status | ev_vec;

		// Read data and error answer are prepared in the setup cycle.
		if (rd_setup) begin
			st_next.pslverr = !reg_mapped(paddr) ||
				(pwrite && acc_idx == `OSP_IDX_ENTRY_COUNT);
			st_next.prdata  = 32'h00000000;
			if (!pwrite && reg_mapped(paddr)) begin
				case (acc_idx)
					`OSP_IDX_ENTRY_COUNT:   st_next.prdata = {24'h000000, `OSP_RST_ENTRY_COUNT};
					`OSP_IDX_MODE_SELECT:   st_next.prdata = {16'h0000, st_reg.mode};
					`OSP_IDX_CYCLE_PERIOD:  st_next.prdata = st_reg.cycle_period;
					`OSP_IDX_OUTPUT_SHIFT:  st_next.prdata = st_reg.output_shift;
					`OSP_IDX_SUPPORTED:     st_next.prdata = {16'h0000, st_reg.supported};
					`OSP_IDX_MIN_CYCLE:     st_next.prdata = st_reg.min_cycle;
					`OSP_IDX_EVENT_GAP:     st_next.prdata = st_reg.event_gap;
					`OSP_IDX_MEASURE_CTRL:  st_next.prdata = {16'h0000, st_reg.measure_ctrl};
					`OSP_IDX_OUTPUT_DELAY:  st_next.prdata = st_reg.output_delay;
					`OSP_IDX_MISSED_COUNT:  st_next.prdata = {16'h0000, cnt_val[0]};
					`OSP_IDX_OVERRUN_COUNT: st_next.prdata = {16'h0000, cnt_val[1]};
					`OSP_IDX_SHORT_GAP:     st_next.prdata = {16'h0000, cnt_val[2]};
					`OSP_IDX_LATE_FLAG:     st_next.prdata = {31'h00000000, st_reg.late_flag};
					`OSP_IDX_IRQ_STATUS:    st_next.prdata = {28'h0000000, st_reg.irq_status};
					`OSP_IDX_IRQ_MASK:      st_next.prdata = {28'h0000000, st_reg.irq_mask};
					default:                st_next.prdata = 32'h00000000;
				endcase
			end
		end else if (!psel) begin
			st_next.pslverr = 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg              <= '0;
			st_reg.mode         <= `OSP_RST_MODE_SELECT;
			st_reg.cycle_period <= `OSP_RST_CYCLE_PERIOD;
			st_reg.output_shift <= `OSP_RST_OUTPUT_SHIFT;
			st_reg.supported    <= `OSP_RST_SUPPORTED;
			st_reg.min_cycle    <= `OSP_RST_MIN_CYCLE;
			st_reg.event_gap    <= `OSP_RST_EVENT_GAP;
			st_reg.measure_ctrl <= `OSP_RST_MEASURE_CTRL;
			st_reg.output_delay <= `OSP_RST_OUTPUT_DELAY;
			st_reg.irq_mask     <= `OSP_RST_IRQ_MASK;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------

	// Zero-wait slave: every access completes in its first access cycle.
	assign pready         = 1'b1;
	assign prdata         = st_reg.prdata;
	assign pslverr        = st_reg.pslverr && psel && penable;
	assign out_update     = st_reg.out_update;
	assign sync_error_pdo = st_reg.late_flag;
	assign irq            = |(st_reg.irq_status & st_reg.irq_mask);

endmodule // osp_sync_params

// ---- src/osp_consts.svh ----
// Offsets, field positions, reset values and timing constants of the output sync parameter block.
`ifndef OSP_CONSTS_SVH
`define OSP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define OSP_IDX_ENTRY_COUNT    8'h00
`define OSP_IDX_MODE_SELECT    8'h01
`define OSP_IDX_CYCLE_PERIOD   8'h02
`define OSP_IDX_OUTPUT_SHIFT   8'h03
`define OSP_IDX_SUPPORTED      8'h04
`define OSP_IDX_MIN_CYCLE      8'h05
`define OSP_IDX_EVENT_GAP      8'h06
`define OSP_IDX_MEASURE_CTRL   8'h08
`define OSP_IDX_OUTPUT_DELAY   8'h09
`define OSP_IDX_MISSED_COUNT   8'h0B
`define OSP_IDX_OVERRUN_COUNT  8'h0C
`define OSP_IDX_SHORT_GAP      8'h0D
`define OSP_IDX_LATE_FLAG      8'h20
`define OSP_IDX_IRQ_STATUS     8'h21
`define OSP_IDX_IRQ_MASK       8'h22

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OSP_RST_ENTRY_COUNT    8'h14
`define OSP_RST_MODE_SELECT    16'h0001
`define OSP_RST_CYCLE_PERIOD   32'h000AAE60
`define OSP_RST_OUTPUT_SHIFT   32'h00000000
`define OSP_RST_SUPPORTED      16'h8007
`define OSP_RST_MIN_CYCLE      32'h000AAE60
`define OSP_RST_EVENT_GAP      32'h00000000
`define OSP_RST_MEASURE_CTRL   16'h0000
`define OSP_RST_OUTPUT_DELAY   32'h00000000
`define OSP_RST_IRQ_MASK       4'h0

// ----------------------------------------------------------------------------
// Mode encodings and field positions
// ----------------------------------------------------------------------------
`define OSP_MODE_FREE_RUN      16'h0000
`define OSP_MODE_SM_EVENT      16'h0001
`define OSP_MODE_DC_SYNC0      16'h0002
`define OSP_MODE_DC_SYNC1      16'h0003
`define OSP_MEASURE_BIT        0
`define OSP_IRQ_MISSED_BIT     0
`define OSP_IRQ_OVERRUN_BIT    1
`define OSP_IRQ_SHORT_BIT      2
`define OSP_IRQ_LATE_BIT       3
`define OSP_IRQ_WIDTH          4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OSP_CLK_PERIOD_NS      20
`define OSP_NS_PER_CYCLE       32'(`OSP_CLK_PERIOD_NS)

`endif

// ---- src/osp_pkg.sv ----
// Types shared by the output sync parameter block.
package osp_pkg;

	typedef logic [31:0] osp_word_t;

	typedef struct packed {
		logic [15:0] count;
	} osp_cnt_s;

	typedef struct packed {
		logic [15:0] mode;
		osp_word_t   cycle_period;
		osp_word_t   output_shift;
		logic [15:0] supported;
		osp_word_t   min_cycle;
		osp_word_t   event_gap;
		logic [15:0] measure_ctrl;
		osp_word_t   output_delay;
		logic        late_flag;
		logic [3:0]  irq_status;
		logic [3:0]  irq_mask;
		osp_word_t   prdata;
		logic        pslverr;
		osp_word_t   timer_ns;
		osp_word_t   cyc_ns;
		osp_word_t   s0_ns;
		osp_word_t   s1_ns;
		osp_word_t   arm_ns;
		logic        armed;
		logic        sm_seen;
		logic        busy;
		logic        data_seen;
		logic        out_update;
	} osp_state_s;

endpackage

// ---- src/osp_sat_counter.sv ----
// Saturating diagnostic counter with software clear.
`timescale 1ns/1ps
`include "osp_consts.svh"

module osp_sat_counter
	import osp_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             inc,
	input  wire logic             clr,
	output logic [WIDTH-1:0]      count
);

	osp_cnt_s cnt_reg;
	osp_cnt_s cnt_next;

	// An event in the clearing cycle is kept, so the count restarts at one.
	always_comb begin
		cnt_next = cnt_reg;
		if (clr && inc) begin
			cnt_next.count = 16'h0001;
		end else if (clr) begin
			cnt_next.count = 16'h0000;
		end else if (inc && (cnt_reg.count != 16'hFFFF)) begin
			cnt_next.count = cnt_reg.count + 16'h0001;
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign count = cnt_reg.count[WIDTH-1:0];

endmodule // osp_sat_counter

// ---- tb/osp_sync_params_props.sv ----
// Port-level assertions for the output sync parameter block, bound to its top module.
`timescale 1ns/1ps

module osp_sync_params_props
	import osp_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sm_event,
	input wire logic        sync0,
	input wire logic        sync1,
	input wire logic        op_state,
	input wire logic        out_data_ready,
	input wire logic        out_done,
	input wire logic        out_update,
	input wire logic        sync_error_pdo,
	input wire logic        irq
);
	// ------------------------------------------------------------------
	// Shadow of the settings that the checks depend on
	// ------------------------------------------------------------------
	logic        wr;
	logic [15:0] mode_reg;
	logic        shift_zero_reg, delay_zero_reg, mask_zero_reg;

	// A write lands at the edge that ends its access phase.
	assign wr = psel && penable && pwrite;

	// Byte addresses are four times the index, so mode sits at 0x04 and the mask at 0x88.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg       <= 16'h0001;
			shift_zero_reg <= 1'b1;
			delay_zero_reg <= 1'b1;
			mask_zero_reg  <= 1'b1;
		end else if (wr) begin
			if (paddr == 8'h04) mode_reg <= pwdata[15:0];
			if (paddr == 8'h0C) shift_zero_reg <= (pwdata == 32'h0);
			if (paddr == 8'h24) delay_zero_reg <= (pwdata == 32'h0);
			if (paddr == 8'h88) mask_zero_reg <= (pwdata[3:0] == 4'h0);
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_ready_always: assert property (pready)
		else $error("pready low");
	chk_err_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	chk_bad_addr: assert property (psel && penable && (paddr[1:0] != 2'b00 || paddr[7:2] == 6'h07)
		|-> pslverr && prdata == 32'h0) else $error("bad address accepted");
	chk_count_ro: assert property (psel && penable && paddr == 8'h00
		|-> pslverr == pwrite && (pwrite || prdata == 32'h14)) else $error("entry count wrong");
	chk_sm_strobe: assert property (mode_reg == 16'h0001 && sm_event |=> out_update)
		else $error("no strobe after sm event");
	chk_mode_idle: assert property (mode_reg > 16'h0003 |=> !out_update)
		else $error("strobe in unknown mode");
	chk_shift_zero: assert property (mode_reg == 16'h0002 && shift_zero_reg && sync0 |-> ##2 out_update)
		else $error("no strobe after sync0");
	chk_delay_zero: assert property (mode_reg == 16'h0003 && delay_zero_reg && sync1 |-> ##2 out_update)
		else $error("no strobe after sync1");
	chk_pdo_flag: assert property (psel && penable && !pwrite && paddr == 8'h80 && $stable(sync_error_pdo)
		|-> prdata[0] == sync_error_pdo) else $error("pdo flag differs");
	chk_irq_mask: assert property (mask_zero_reg |-> !irq)
		else $error("irq while masked");
endmodule // osp_sync_params_props

bind osp_sync_params osp_sync_params_props chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .sm_event, .sync0, .sync1, .op_state, .out_data_ready, .out_done,
	.out_update, .sync_error_pdo, .irq);

// ---- tb/osp_event_src.sv ----
// Behavioural model of the sync unit and application that feed the block's event inputs.
`timescale 1ns/1ps

module osp_event_src (
	input  wire logic pclk,
	output logic      sm_event,
	output logic      sync0,
	output logic      sync1,
	output logic      out_data_ready,
	output logic      out_done
);
	logic [4:0] ev_reg = 5'h00;

	// Event lines idle low and carry one-cycle strobes only.
	assign {out_done, out_data_ready, sync1, sync0, sm_event} = ev_reg;

	// Raise the chosen lines for one clock; the caller sets the spacing between events.
	task automatic pulse(input logic [4:0] m);
		@(posedge pclk);
		ev_reg <= m;
		@(posedge pclk);
		ev_reg <= 5'h00;
	endtask
endmodule // osp_event_src

// ---- tb/test_osp_sync_params.sv ----
// Self-checking testbench for the output sync parameter block.
`timescale 1ns/1ps

module test_osp_sync_params import osp_pkg::*;;
	// ------------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------------
	localparam logic [4:0] SM = 5'h01;
	localparam logic [4:0] S0 = 5'h02;
	localparam logic [4:0] S1 = 5'h04;
	logic        pclk, presetn, psel, penable, pwrite, op_state, pready, pslverr, re;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic        sm_event, sync0, sync1, out_data_ready, out_done, out_update, sync_error_pdo, irq;
	int          fails, checked;

	osp_sync_params uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .sm_event, .sync0, .sync1, .op_state, .out_data_ready, .out_done, .out_update,
		.sync_error_pdo, .irq);
	osp_event_src ev (.pclk, .sm_event, .sync0, .sync1, .out_data_ready, .out_done);

	// Free-running 50 MHz clock.
	always #10 pclk = ~pclk;

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request stands until pready is seen high at an edge.
	task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i[5:0], 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		xfer(1'b1, i, d);
	endtask

	task automatic rchk(input logic [7:0] i, input logic [31:0] x);
		xfer(1'b0, i, 32'h0);
		cmp(rv, x);
	endtask

	// Count clocks from an event to the output strobe; bounded so a silent design cannot hang.
	task automatic lat(input logic [4:0] m, input int x);
		int n;
		n = 0;
		ev.pulse(m);
		do begin
			@(negedge pclk);
			n++;
		end while (out_update !== 1'b1 && n < 40);
		cmp(32'(n), 32'(x));
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_regs();
		logic [7:0]  ix [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0B,
			8'h0C, 8'h0D, 8'h20, 8'h21, 8'h22};
		logic [31:0] rs [6] = '{32'h14, 32'h1, 32'h000AAE60, 32'h0, 32'h8007, 32'h000AAE60};
		for (int k = 0; k < 15; k++) begin
			rchk(ix[k], (k < 6) ? rs[k] : 32'h0);
		end
		ev.pulse(SM);
		for (int m = 0; m <= 4; m++) begin
			wr(8'h01, 32'(m));
			rchk(8'h01, 32'(m));
		end
		wr(8'h00, 32'h5);
		cmp(32'(re), 32'h1);
		rchk(8'h00, 32'h14);
		rchk(8'h07, 32'h0);
		cmp(32'(re), 32'h1);
	endtask

	// A 100 ns free-run period has to strobe every fifth clock.
	task automatic t_free();
		int n;
		n = 0;
		wr(8'h02, 32'h64);
		wr(8'h01, 32'h0);
		repeat (10) @(negedge pclk);
		repeat (50) begin
			@(negedge pclk);
			n += out_update;
		end
		cmp(32'(n), 32'hA);
	endtask

	// Second sync0 arrives with no sm event, no finished cycle and no data; sync1 comes only 40 ns on.
	task automatic t_diag();
		wr(8'h06, 32'h3E8);
		op_state <= 1'b1;
		wr(8'h01, 32'h2);
		ev.pulse(S0);
		for (int k = 0; k < 4; k++) wr(8'h0B + 8'(k), 32'h0);
		wr(8'h20, 32'h0);
		wr(8'h21, 32'hF);
		wr(8'h22, 32'h1);
		ev.pulse(S0);
		ev.pulse(S1);
		rchk(8'h0B, 32'h1);
		rchk(8'h0C, 32'h1);
		rchk(8'h0D, 32'h1);
		rchk(8'h20, 32'h1);
		cmp(32'(sync_error_pdo), 32'h1);
		cmp(32'(irq), 32'h1);
		wr(8'h22, 32'h0);
		// The write lands at the edge the task returns on, so look once the registers have settled.
		@(negedge pclk);
		cmp(32'(irq), 32'h0);
		wr(8'h22, 32'h1);
		wr(8'h21, 32'h1);
		@(negedge pclk);
		cmp(32'(irq), 32'h0);
		rchk(8'h21, 32'hE);
		wr(8'h0B, 32'h5);
		rchk(8'h0B, 32'h1);
		wr(8'h0B, 32'h0);
		rchk(8'h0B, 32'h0);
		// A well-served cycle: SM event, finished cycle and fresh data all come with sync0.
		wr(8'h20, 32'h0);
		ev.pulse(SM | S0 | 5'h18);
		rchk(8'h0B, 32'h0);
		rchk(8'h0C, 32'h1);
		rchk(8'h20, 32'h0);
	endtask

	// Start clears the maxima, a 100 ns gap is captured, and after stop a longer gap is ignored.
	task automatic t_meas();
		logic [31:0] g;
		wr(8'h01, 32'h3);
		wr(8'h08, 32'h1);
		rchk(8'h06, 32'h0);
		rchk(8'h05, 32'h0);
		ev.pulse(S0);
		repeat (3) @(posedge pclk);
		ev.pulse(S1);
		xfer(1'b0, 8'h06, 32'h0);
		g = rv;
		cmp(g, 32'h64);
		wr(8'h08, 32'h0);
		ev.pulse(S0);
		repeat (10) @(posedge pclk);
		ev.pulse(S1);
		rchk(8'h06, g);
		wr(8'h08, 32'h1);
		rchk(8'h06, 32'h0);
		wr(8'h08, 32'h0);
	endtask

	task automatic t_dc();
		wr(8'h01, 32'h2);
		wr(8'h03, 32'h64);
		lat(S0, 6);
		wr(8'h01, 32'h3);
		wr(8'h09, 32'h3C);
		lat(S1, 4);
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Reset for ten clocks, then run every scenario in turn.
	initial begin
		{pclk, presetn, psel, penable, pwrite, op_state} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		fails = 0;
		checked = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_free();
		t_diag();
		t_meas();
		t_dc();
		complete_run();
	end

	// The scenarios need about 330 clocks; ten thousand means something hung.
	initial begin
		#200000;
		fails++;
		complete_run();
	end
endmodule // test_osp_sync_params
